// ---- design/flash_isp_cfg.svh ----
// Purpose: Offsets, field positions, reset values and counts for flash_isp_boot_control
// Assumes: Avalon-MM byte addresses, one 32-bit word per register, data in bits 7:0
// Notes:   Definitions only
//
// Notes on behaviour
// - Eight-bit write byte register, reachable by software
// - Pulse width follows pulse select register value
// - Reset loads pulse select with 01111011
// - Flash write/erase only while executing boot ROM
// - Jump-to-boot enters boot ROM only when unlocked
// - Unlock only when bits 7:2 equal 100110
// - Unlock lasts exactly eight instruction cycles
// - Mismatch leaves unlock clear, jump stays in flash
// - Breakpoint in emulation freezes unlock counter
// - Unlock counter keeps running during interrupts
// - High-voltage pin at reset forces boot ROM 0000
// - Ordinary reset follows exit bit, flash 0000
// - Forced entry never alters exit or security bits
// - High voltage: load clock out, pin reads one
// - Wait pin low, debounce, then enable serial
// - Exit bit 1 starts flash, 0 starts boot ROM
`ifndef FLASH_ISP_CFG_SVH
`define FLASH_ISP_CFG_SVH

`define OFS_WRITE_BYTE   4'h0
`define OFS_PULSE_SEL    4'h4
`define OFS_UNLOCK_CODE  4'h8
`define OFS_STATUS       4'hc

`define PULSE_SEL_RESET  8'h7b
`define UNLOCK_PATTERN   6'h26
`define UNLOCK_CYCLES    4'h8
`define START_ADDR       16'h0000

// mclk cycles per instruction cycle, and debounce length in instruction cycles
`define INSTR_CLKS       4'ha
`define DEBOUNCE_CYCLES  4'h4

`define ST_UNLOCK        0
`define ST_REFUSED       1
`define ST_BUSY          2
`define ST_IN_BOOT       3
`define ST_FORCED        4
`define ST_SERIAL_EN     5

`endif

// ---- design/flash_isp_pkg.sv ----
// Purpose: Types shared by the flash ISP boot control block
// Assumes: Nothing beyond SystemVerilog packages
// Notes:   Constants live in flash_isp_cfg.svh
package flash_isp_pkg;

    // CPU-side events, each a one-cycle pulse except the two levels
    typedef struct packed {
        logic jumpToBoot;
        logic returnToFlash;
        logic progStart;
        logic emulMode;
        logic breakpoint;
    } cpu_evt_s;

    // Execution answer to the CPU
    typedef struct packed {
        logic        inBoot;
        logic        jumpBoot;
        logic        jumpFlash;
        logic [15:0] startAddr;
    } exec_s;

    typedef enum logic [1:0] {
        PS_IDLE  = 2'b01,
        PS_PULSE = 2'b10
    } prog_state_e;

endpackage

// ---- design/flash_isp_boot_control.sv ----
// Purpose: Write byte and pulse width registers, keyed boot ROM entry, forced boot entry
// Assumes: One clock mclk at 50 MHz, synchronous active-low rstn, inputs synchronous
// Notes:   Registers over Avalon-MM; every access gets exactly one wait state
//
// The Avalon-MM register port and the address map were decided locally.
`timescale 1ns/100ps
`include "flash_isp_cfg.svh"

module flash_isp_boot_control (
    // Clock and reset
    input  wire logic                   mclk,
    input  wire logic                   rstn,
    // Avalon-MM slave
    input  wire logic [3:0]             address,
    input  wire logic                   read,
    input  wire logic                   write,
    input  wire logic [3:0]             byteenable,
    input  wire logic [31:0]            writedata,
    output logic      [31:0]            readdata,
    output logic                        waitrequest,
    // CPU core
    input  wire flash_isp_pkg::cpu_evt_s cpuEvt,
    output flash_isp_pkg::exec_s        execOut,
    // Flash array and option bits
    input  wire logic                   flashExitBit,
    output logic [7:0]                  programWriteByte,
    output logic [6:0]                  pulseWidthCode,
    output logic                        progPulse,
    output logic                        progDone,
    // Pins
    input  wire logic                   forcedBootHv,
    input  wire logic                   forcedBootPinIn,
    output logic                        forcedBootPinLevel,
    output logic                        loadClockOut,
    output logic                        loadClockOe,
    output logic                        serialEnable
);
    import flash_isp_pkg::*;

    logic [7:0]  writeByte_r;
    logic [7:0]  pulseSel_r;
    logic        unlock_r;
    logic [3:0]  unlockCnt_r;
    logic [3:0]  divCnt_r;
    logic        instrTick_r;
    logic        started_r;
    logic        inBoot_r;
    logic        forced_r;
    logic        jumpBoot_r;
    logic        jumpFlash_r;
    logic        refused_r;
    prog_state_e progState_r;
    logic [6:0]  pulseCnt_r;
    logic        progDone_r;
    logic        loadClk_r;
    logic        pinLevel_r;
    logic [3:0]  debCnt_r;
    logic        serialEn_r;
    logic        waitReq_r;
    logic [31:0] rdata_r;
    logic        busReq;
    logic        wrTake;
    logic        unlockMatch;
    logic        freeze;
    logic [7:0]  statusWord;

    // ------------------------------------------------------------------
    // Bus slave
    // ------------------------------------------------------------------
    // One wait state: request seen with waitrequest high, answered next edge
    assign busReq      = read | write;
    assign wrTake      = write & ~waitReq_r & byteenable[0];
    assign unlockMatch = wrTake && address == `OFS_UNLOCK_CODE
                         && writedata[7:2] == `UNLOCK_PATTERN;
    assign statusWord  = {2'h0, serialEn_r, forced_r, inBoot_r,
                          progState_r == PS_PULSE, refused_r, unlock_r};

    always_ff @(posedge mclk) begin
        if (!rstn) begin
            waitReq_r <= 1'b1;
        end else begin
            waitReq_r <= !(busReq && waitReq_r);
        end
    end

    always_ff @(posedge mclk) begin
        if (!rstn) begin
            rdata_r <= 32'h0;
        end else if (read && waitReq_r) begin
            unique case (address)
                `OFS_WRITE_BYTE: rdata_r <= {24'h0, writeByte_r};
                `OFS_PULSE_SEL:  rdata_r <= {24'h0, 1'b0, pulseSel_r[6:0]};
                `OFS_STATUS:     rdata_r <= {24'h0, statusWord};
                default:         rdata_r <= 32'h0;
            endcase
        end
    end

    // ------------------------------------------------------------------
    // Write byte and pulse width registers
    // ------------------------------------------------------------------
    // Reset value of the write byte is unspecified; zero keeps outputs defined
    always_ff @(posedge mclk) begin
        if (!rstn) begin
            writeByte_r <= 8'h0;
        end else if (wrTake && address == `OFS_WRITE_BYTE) begin
            writeByte_r <= writedata[7:0];
        end
    end

    always_ff @(posedge mclk) begin
        if (!rstn) begin
            pulseSel_r <= `PULSE_SEL_RESET;
        end else if (wrTake && address == `OFS_PULSE_SEL) begin
            pulseSel_r <= {1'b0, writedata[6:0]};
        end
    end

    // ------------------------------------------------------------------
    // Instruction cycle divider
    // ------------------------------------------------------------------
    always_ff @(posedge mclk) begin
        if (!rstn) begin
            divCnt_r    <= 4'h0;
            instrTick_r <= 1'b0;
        end else begin
            instrTick_r <= divCnt_r == `INSTR_CLKS - 4'h1;
            divCnt_r    <= (divCnt_r == `INSTR_CLKS - 4'h1) ? 4'h0 : divCnt_r + 4'h1;
        end
    end

    // ------------------------------------------------------------------
    // Boot unlock
    // ------------------------------------------------------------------
    // Interrupts do not gate the count, so an unlock can lapse inside an ISR
    assign freeze = cpuEvt.emulMode & cpuEvt.breakpoint;

    always_ff @(posedge mclk) begin
        if (!rstn) begin
            unlock_r    <= 1'b0;
            unlockCnt_r <= 4'h0;
        end else if (unlockMatch) begin
            unlock_r    <= 1'b1;
            unlockCnt_r <= `UNLOCK_CYCLES;
        end else if (unlock_r && instrTick_r && !freeze) begin
            unlockCnt_r <= unlockCnt_r - 4'h1;
            unlock_r    <= unlockCnt_r != 4'h1;
        end
    end

    always_ff @(posedge mclk) begin
        if (!rstn) begin
            jumpBoot_r  <= 1'b0;
            jumpFlash_r <= 1'b0;
        end else begin
            jumpBoot_r  <= cpuEvt.jumpToBoot & unlock_r;
            jumpFlash_r <= cpuEvt.jumpToBoot & ~unlock_r;
        end
    end

    // ------------------------------------------------------------------
    // Execution space and reset entry
    // ------------------------------------------------------------------
    // Option bits are only read here; nothing in this block can change them
    always_ff @(posedge mclk) begin
        if (!rstn) begin
            started_r <= 1'b0;
            inBoot_r  <= 1'b0;
            forced_r  <= 1'b0;
        end else if (!started_r) begin
            started_r <= 1'b1;
            forced_r  <= forcedBootHv;
            inBoot_r  <= forcedBootHv | ~flashExitBit;
        end else if (jumpBoot_r) begin
            inBoot_r <= 1'b1;
        end else if (cpuEvt.returnToFlash) begin
            inBoot_r <= 1'b0;
        end
    end

    // ------------------------------------------------------------------
    // Program / erase timing pulse
    // ------------------------------------------------------------------
    always_ff @(posedge mclk) begin
        if (!rstn) begin
            progState_r <= PS_IDLE;
            pulseCnt_r  <= 7'h0;
            progDone_r  <= 1'b0;
        end else begin
            progDone_r <= 1'b0;
            unique case (progState_r)
                PS_IDLE: if (cpuEvt.progStart && inBoot_r) begin
                    progState_r <= PS_PULSE;
                    pulseCnt_r  <= (pulseSel_r[6:0] == 7'h0) ? 7'h1 : pulseSel_r[6:0];
                end
                PS_PULSE: if (instrTick_r) begin
                    pulseCnt_r <= pulseCnt_r - 7'h1;
                    if (pulseCnt_r == 7'h1) begin
                        progState_r <= PS_IDLE;
                        progDone_r  <= 1'b1;
                    end
                end
            endcase
        end
    end

    // Sticky refusal of a start outside boot ROM; a new refusal beats the clear
    always_ff @(posedge mclk) begin
        if (!rstn) begin
            refused_r <= 1'b0;
        end else if (cpuEvt.progStart && !inBoot_r) begin
            refused_r <= 1'b1;
        end else if (wrTake && address == `OFS_STATUS && writedata[`ST_REFUSED]) begin
            refused_r <= 1'b0;
        end
    end

    // ------------------------------------------------------------------
    // Forced boot pin and serial enable
    // ------------------------------------------------------------------
    always_ff @(posedge mclk) begin
        if (!rstn) begin
            loadClk_r  <= 1'b0;
            pinLevel_r <= 1'b0;
        end else begin
            pinLevel_r <= forcedBootHv | forcedBootPinIn;
            if (!forcedBootHv) begin
                loadClk_r <= 1'b0;
            end else if (instrTick_r) begin
                loadClk_r <= ~loadClk_r;
            end
        end
    end

    always_ff @(posedge mclk) begin
        if (!rstn) begin
            debCnt_r   <= 4'h0;
            serialEn_r <= 1'b0;
        end else if (!forced_r || serialEn_r) begin
            debCnt_r <= 4'h0;
        end else if (pinLevel_r) begin
            debCnt_r <= 4'h0;
        end else if (instrTick_r) begin
            debCnt_r <= debCnt_r + 4'h1;
            if (debCnt_r == `DEBOUNCE_CYCLES - 4'h1) begin
                serialEn_r <= 1'b1;
            end
        end
    end

    // ------------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------------
    assign readdata           = rdata_r;
    assign waitrequest        = waitReq_r;
    assign execOut            = '{inBoot: inBoot_r, jumpBoot: jumpBoot_r,
                                  jumpFlash: jumpFlash_r, startAddr: `START_ADDR};
    assign programWriteByte   = writeByte_r;
    assign pulseWidthCode     = pulseSel_r[6:0];
    assign progPulse          = progState_r[1];
    assign progDone           = progDone_r;
    assign forcedBootPinLevel = pinLevel_r;
    assign loadClockOut       = loadClk_r;
    assign loadClockOe        = forced_r;
    assign serialEnable       = serialEn_r;

    // ------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rstn);

    logic [3:0] tickSeen_r;
    always_ff @(posedge mclk) begin
        if (!rstn || unlockMatch) begin
            tickSeen_r <= 4'h0;
        end else if (unlock_r && instrTick_r && !freeze) begin
            // Frozen ticks do not count toward the unlock length
            tickSeen_r <= tickSeen_r + 4'h1;
        end
    end

    property p_unlock_set;
        unlockMatch |=> unlock_r && unlockCnt_r == 4'h8;
    endproperty
    a_unlock_set: assert property (p_unlock_set) else $error("unlock not set");

    property p_unlock_miss;
        !unlock_r && !unlockMatch |=> !unlock_r;
    endproperty
    a_unlock_miss: assert property (p_unlock_miss) else $error("unlock set on mismatch");

    property p_unlock_len;
        $fell(unlock_r) && !cpuEvt.emulMode |-> $past(tickSeen_r) == 4'h7;
    endproperty
    a_unlock_len: assert property (p_unlock_len) else $error("unlock length wrong");

    property p_jump_gate;
        jumpBoot_r |-> $past(unlock_r) && $past(cpuEvt.jumpToBoot);
    endproperty
    a_jump_gate: assert property (p_jump_gate) else $error("boot jump while locked");

    property p_freeze;
        unlock_r && freeze && !unlockMatch |=> unlockCnt_r == $past(unlockCnt_r);
    endproperty
    a_freeze: assert property (p_freeze) else $error("counter moved at breakpoint");

    property p_count_on;
        unlock_r && instrTick_r && !freeze && !unlockMatch
            |=> unlockCnt_r == $past(unlockCnt_r) - 4'h1;
    endproperty
    a_count_on: assert property (p_count_on) else $error("unlock counter stalled");

    property p_reset_sel;
        !$past(rstn) |-> pulseSel_r == 8'h7b;
    endproperty
    a_reset_sel: assert property (p_reset_sel) else $error("pulse select reset value");

    property p_forced_entry;
        !started_r && forcedBootHv |=> inBoot_r && forced_r;
    endproperty
    a_forced_entry: assert property (p_forced_entry) else $error("forced entry missed");

    property p_prog_boot;
        $rose(progPulse) |-> $past(inBoot_r);
    endproperty
    a_prog_boot: assert property (p_prog_boot) else $error("program outside boot ROM");

    property p_pin_one;
        forcedBootHv |=> forcedBootPinLevel;
    endproperty
    a_pin_one: assert property (p_pin_one) else $error("pin not read as one");

    c_unlock_jump: cover property (unlock_r && cpuEvt.jumpToBoot ##1 jumpBoot_r);
    c_unlock_expire: cover property ($fell(unlock_r));
    c_prog_done: cover property (progPulse ##[1:300] progDone);
    c_serial_on: cover property ($rose(serialEn_r));

endmodule

// ---- verif/isp_host_model.sv ----
// Purpose: Programming host that applies high voltage to the forced boot pin
// Assumes: applyHv only changes while the bench holds reset
// Notes:   Pin is driven low after release, so the debounce sees a real low
`timescale 1ns/100ps

module isp_host_model #(
    parameter int HOLD_CLKS = 40
) (
    // Clock, reset and control
    input  wire logic mclk,
    input  wire logic rstn,
    input  wire logic applyHv,
    // Pin drive
    output logic      forcedBootHv,
    output logic      forcedBootPinIn
);
    int holdCnt;

    // Voltage goes up during reset and stays well past three instruction cycles
    always @(posedge mclk) begin
        if (!rstn) begin
            holdCnt <= 0;
            forcedBootHv <= applyHv;
            forcedBootPinIn <= applyHv;
        end else if (forcedBootHv) begin
            holdCnt <= holdCnt + 1;
            if (holdCnt == HOLD_CLKS) begin
                forcedBootHv <= 1'b0;
                forcedBootPinIn <= 1'b0;
            end
        end
    end
endmodule

// ---- verif/test_flash_isp_boot_control.sv ----
// Purpose: Self-checking bench for flash_isp_boot_control
// Assumes: One wait state per bus access, instruction tick every 10 mclk
// Notes:   Unlock and pulse lengths are checked inside tick-alignment windows
`timescale 1ns/100ps
`include "flash_isp_cfg.svh"

module test_flash_isp_boot_control;
    import flash_isp_pkg::*;
    // ------------------------------------------------------------
    // Signals
    // ------------------------------------------------------------
    localparam cpu_evt_s EV_JUMP = 5'b10000;
    localparam cpu_evt_s EV_RET  = 5'b01000;
    localparam cpu_evt_s EV_PROG = 5'b00100;
    logic        mclk      = 1'b0;
    logic        rstn      = 1'b0;
    logic [3:0]  address   = 4'h0;
    logic        read      = 1'b0;
    logic        write     = 1'b0;
    logic [31:0] writedata = 32'h0;
    cpu_evt_s    evt       = '0;
    logic        flashExit = 1'b1;
    logic        applyHv   = 1'b0;
    logic [31:0] readdata;
    logic        waitrequest;
    exec_s       ex;
    logic        hv, pinIn, pinLevel, ldClk, ldOe, serEn, pulse, done;
    logic [7:0]  wrByte;
    logic [6:0]  pwCode;
    int          n_mismatch = 0;
    int          checks     = 0;
    int          cyc        = 0;

    always #10 mclk = ~mclk;

    flash_isp_boot_control flash_isp_boot_control_inst (
        .mclk(mclk), .rstn(rstn), .address(address), .read(read), .write(write),
        .byteenable(4'hf), .writedata(writedata), .readdata(readdata),
        .waitrequest(waitrequest), .cpuEvt(evt), .execOut(ex), .flashExitBit(flashExit),
        .programWriteByte(wrByte), .pulseWidthCode(pwCode), .progPulse(pulse),
        .progDone(done), .forcedBootHv(hv), .forcedBootPinIn(pinIn),
        .forcedBootPinLevel(pinLevel), .loadClockOut(ldClk), .loadClockOe(ldOe),
        .serialEnable(serEn));

    isp_host_model isp_host_model_inst (
        .mclk(mclk), .rstn(rstn), .applyHv(applyHv),
        .forcedBootHv(hv), .forcedBootPinIn(pinIn));

    // ------------------------------------------------------------
    // Shared tasks
    // ------------------------------------------------------------
    task automatic finish_test;
        if (n_mismatch == 0 && checks > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    always @(posedge mclk) begin
        cyc++;
        if (cyc == 20000) begin
            n_mismatch++;
            finish_test;
        end
    end

    task automatic chk(input string what, input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask

    // Request held until the rising edge that samples waitrequest low
    task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] wd,
                       output logic [31:0] rd);
        @(posedge mclk);
        address <= a;
        writedata <= wd;
        read <= ~wr;
        write <= wr;
        @(posedge mclk);
        while (waitrequest !== 1'b0) @(posedge mclk);
        rd = readdata;
        read <= 1'b0;
        write <= 1'b0;
    endtask

    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        logic [31:0] dummy;
        bus(1'b1, a, {24'h0, d}, dummy);
    endtask

    task automatic rdchk(input string what, input logic [3:0] a, input logic [31:0] mask,
                         input logic [31:0] exp);
        logic [31:0] d;
        bus(1'b0, a, 32'h0, d);
        chk(what, d & mask, exp);
    endtask

    task automatic strobe(input cpu_evt_s s);
        @(posedge mclk);
        evt <= evt | s;
        @(posedge mclk);
        evt <= evt & ~s;
    endtask

    task automatic jump(input logic expBoot);
        int nb;
        int nf;
        nb = 0;
        nf = 0;
        strobe(EV_JUMP);
        repeat (3) begin
            @(negedge mclk);
            nb += (ex.jumpBoot === 1'b1);
            nf += (ex.jumpFlash === 1'b1);
        end
        chk("jumpBoot", nb, {31'h0, expBoot});
        chk("jumpFlash", nf, {31'h0, !expBoot});
    endtask

    task automatic do_reset(input logic hvOn, input logic exitBit);
        @(posedge mclk);
        rstn <= 1'b0;
        applyHv <= hvOn;
        flashExit <= exitBit;
        repeat (8) @(posedge mclk);
        rstn <= 1'b1;
        repeat (2) @(posedge mclk);
    endtask

    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task automatic t_registers;
        logic [7:0] v [2] = '{8'ha5, 8'h5a};
        do_reset(1'b0, 1'b1);
        rdchk("pulse select reset", `OFS_PULSE_SEL, 32'hffffffff, 32'h7b);
        chk("inBoot after reset", ex.inBoot, 32'h0);
        chk("startAddr", ex.startAddr, `START_ADDR);
        foreach (v[i]) begin
            wr(`OFS_WRITE_BYTE, v[i]);
            rdchk("write byte", `OFS_WRITE_BYTE, 32'hffffffff, {24'h0, v[i]});
            chk("programWriteByte", wrByte, {24'h0, v[i]});
        end
        wr(`OFS_PULSE_SEL, 8'hff);
        rdchk("pulse select bit7", `OFS_PULSE_SEL, 32'hffffffff, 32'h7f);
        chk("pulseWidthCode", pwCode, 32'h7f);
        rdchk("unlock code reads", `OFS_UNLOCK_CODE, 32'hffffffff, 32'h0);
        wr(4'h1, 8'h33);
        rdchk("unmapped read", 4'h1, 32'hffffffff, 32'h0);
        rdchk("write byte kept", `OFS_WRITE_BYTE, 32'hff, 32'h5a);
    endtask

    task automatic t_unlock;
        logic [7:0] bad [3] = '{8'h9c, 8'h1b, 8'hd8};
        logic [7:0] good [4] = '{8'h98, 8'h99, 8'h9a, 8'h9b};
        foreach (bad[i]) begin
            wr(`OFS_UNLOCK_CODE, bad[i]);
            rdchk("unlock on mismatch", `OFS_STATUS, 32'h1, 32'h0);
            jump(1'b0);
        end
        foreach (good[i]) begin
            wr(`OFS_UNLOCK_CODE, good[i]);
            rdchk("unlock on match", `OFS_STATUS, 32'h1, 32'h1);
        end
        repeat (100) @(posedge mclk);
        wr(`OFS_UNLOCK_CODE, 8'h9b);
        repeat (55) @(posedge mclk);
        rdchk("unlock still set", `OFS_STATUS, 32'h1, 32'h1);
        repeat (30) @(posedge mclk);
        rdchk("unlock expired", `OFS_STATUS, 32'h1, 32'h0);
        wr(`OFS_UNLOCK_CODE, 8'h98);
        repeat (45) @(posedge mclk);
        wr(`OFS_UNLOCK_CODE, 8'h98);
        repeat (45) @(posedge mclk);
        rdchk("unlock restarted", `OFS_STATUS, 32'h1, 32'h1);
        repeat (100) @(posedge mclk);
        wr(`OFS_UNLOCK_CODE, 8'h9b);
        evt.emulMode <= 1'b1;
        evt.breakpoint <= 1'b1;
        repeat (200) @(posedge mclk);
        rdchk("unlock frozen", `OFS_STATUS, 32'h1, 32'h1);
        evt.emulMode <= 1'b0;
        evt.breakpoint <= 1'b0;
        repeat (100) @(posedge mclk);
        rdchk("unlock resumed", `OFS_STATUS, 32'h1, 32'h0);
    endtask

    // Pulse select loaded first; write byte left alone while the pulse runs
    task automatic t_program;
        int np;
        int nd;
        wr(`OFS_PULSE_SEL, 8'h03);
        wr(`OFS_UNLOCK_CODE, 8'h9b);
        jump(1'b1);
        repeat (3) @(posedge mclk);
        chk("inBoot", ex.inBoot, 32'h1);
        for (int k = 0; k < 2; k++) begin
            np = 0;
            nd = 0;
            strobe(EV_PROG);
            repeat (60) begin
                @(negedge mclk);
                np += (pulse === 1'b1);
                nd += (done === 1'b1);
            end
            chk("pulse length ok", (k == 0) ? (np >= 21 && np <= 30) : (np == 0), 32'h1);
            chk("progDone count", nd, (k == 0) ? 32'h1 : 32'h0);
            strobe(EV_RET);
            repeat (2) @(posedge mclk);
            chk("inBoot after return", ex.inBoot, 32'h0);
        end
        rdchk("refused flag", `OFS_STATUS, 32'h2, 32'h2);
        wr(`OFS_STATUS, 8'h02);
        rdchk("refused cleared", `OFS_STATUS, 32'h2, 32'h0);
    endtask

    task automatic t_forced;
        int tg;
        logic last;
        tg = 0;
        do_reset(1'b1, 1'b1);
        chk("forced inBoot", ex.inBoot, 32'h1);
        chk("forced startAddr", ex.startAddr, `START_ADDR);
        chk("pin reads one", pinLevel, 32'h1);
        chk("load clock enabled", ldOe, 32'h1);
        last = ldClk;
        repeat (25) begin
            @(negedge mclk);
            tg += (ldClk !== last);
            last = ldClk;
        end
        chk("load clock toggles", tg >= 2, 32'h1);
        chk("serial early", serEn, 32'h0);
        rdchk("forced flag", `OFS_STATUS, 32'h10, 32'h10);
        repeat (150) @(posedge mclk);
        chk("serial enabled", serEn, 32'h1);
        do_reset(1'b0, 1'b1);
        chk("ordinary reset to flash", ex.inBoot, 32'h0);
        chk("load clock released", ldOe, 32'h0);
        chk("serial off", serEn, 32'h0);
        do_reset(1'b0, 1'b0);
        chk("exit bit clear to boot", ex.inBoot, 32'h1);
    endtask

    initial begin
        t_registers;
        t_unlock;
        t_program;
        t_forced;
        finish_test;
    end
endmodule
